// ==== hdl/pci_arb_pkg.sv ====
// Constants and types shared by the secondary bus arbiter
package pci_arb_pkg;

  localparam int NUM_REQ = 9;
  localparam int IDX_W = 4;

  // Register byte addresses
  localparam logic [7:0] ARB_CTRL_ADDR = 8'h48;
  localparam logic [7:0] ARB_STAT_ADDR = 8'h80;

  // Control register field positions
  localparam int EN_LSB = 0;
  localparam int EXT_ARB_BIT = 9;
  localparam int BMTO_EN_BIT = 10;
  localparam int REFRESH_EN_BIT = 11;
  localparam int FAIR_LSB = 12;
  localparam int TOG_EN_BIT = 20;
  localparam int PRIO_LSB = 22;

  // Status register field positions
  localparam int STAT_IDX_LSB = 0;
  localparam int STAT_GRANTED_BIT = 4;
  localparam int STAT_BUSY_BIT = 5;
  localparam int STAT_BROKEN_LSB = 9;
  localparam int STAT_IGNORED_LSB = 18;

  // Values after reset
  localparam logic [8:0] EN_RESET = 9'h1ff;
  localparam logic [7:0] FAIR_RESET = 8'h08;
  localparam logic [8:0] PRIO_RESET = 9'h001;

  // Cycle counts
  localparam logic [4:0] BM_TIMEOUT_CYC = 5'h10;
  localparam logic [1:0] TOG_DELAY_CYC = 2'h2;
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;

  typedef enum logic [1:0] {ARB_IDLE, ARB_GRANT, ARB_BUSY} arb_state_t;

endpackage

// ==== hdl/rr_pick.sv ====
// Round-robin picker: first request after the last winner
`timescale 1ns/100ps
module rr_pick #(
  parameter int N = 9,
  parameter int IW = 4
) (
  // Candidates
  input wire logic [N-1:0] req,
  input wire logic [IW-1:0] last,
  // Result
  output logic found,
  output logic [IW-1:0] idx
);

  always_comb
  begin
    int j;
    j = 0;
    found = 1'b0;
    idx = '0;
    for (int k = N; k >= 1; k--)
    begin
      j = (int'(last) + k) % N;
      if (req[j])
      begin
        found = 1'b1;
        idx = IW'(j);
      end
    end
  end

endmodule // rr_pick

// ==== hdl/pci_secondary_arbiter_control.sv ====
// Secondary PCI bus arbiter with APB control and status registers
//
// Contract
// - Enable bit 0 lets the internal request into arbitration; resets to 1.
// - Enable bits 1 to 8 admit external masters 1 to 8; reset to 1.
// - Read-only bit 9 shows 0 for internal arbiter, 1 for external.
// - Bit 9 takes its reset value from the sampled select strap.
// - With bit 10 set, count 16 idle clocks while granted without FRAME_L.
// - Expired count removes the grant; with bit 10 clear, never removed so.
// - Refresh clear: broken master is ignored forever after releasing its request.
// - Refresh set: broken state clears once all other enabled requesters that request were served.
// - Bits 19:12, reset 08h, set grant hold clocks after another request.
// - Fairness counter reloads on every new grant.
// - Fairness counter decrements only after the next falling FRAME_L edge.
// - Fairness value 00h never removes a grant; owner's release ends it.
// - Toggle bit 20 clear keeps GNT_L asserted after FRAME_L.
// - Toggle set drops GNT_L one clock, two clocks after FRAME_L asserts.
// - Each requester has a priority bit; internal high, masters low at reset.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module pci_secondary_arbiter_control
  import pci_arb_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Bridge internal requester
  input wire logic int_req,
  output logic int_gnt,
  // PCI bus pins
  input wire logic [7:0] req_l,
  output logic [7:0] gnt_l,
  input wire logic frame_l,
  input wire logic irdy_l,
  input wire logic arbiter_select_strap
);

  typedef struct packed {
    logic [7:0] req_m1;
    logic [7:0] req_m2;
    logic frame_m1;
    logic frame_m2;
    logic frame_prev;
    logic irdy_m1;
    logic irdy_m2;
    logic strap_m1;
    logic strap_m2;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [8:0] en;
    logic ext_arb;
    logic bmto_en;
    logic refresh_en;
    logic [7:0] fair;
    logic tog_en;
    logic [8:0] prio;
    arb_state_t state;
    logic [IDX_W-1:0] gidx;
    logic [IDX_W-1:0] last_idx;
    logic [4:0] bm_cnt;
    logic [7:0] fair_cnt;
    logic armed;
    logic [1:0] tog_cnt;
    logic tog_pulse;
    logic [8:0] broken;
    logic [8:0] ignored;
    logic [8:0] served;
    logic [31:0] prdata;
  } arb_regs_t;

  localparam arb_regs_t RESET_ST = '{
    req_m1: '1, req_m2: '1, frame_m1: 1'b1, frame_m2: 1'b1, frame_prev: 1'b1,
    irdy_m1: 1'b1, irdy_m2: 1'b1, strap_m1: 1'b0, strap_m2: 1'b0,
    strap_cnt: '0, strap_done: 1'b0, en: EN_RESET, ext_arb: 1'b0,
    bmto_en: 1'b0, refresh_en: 1'b0, fair: FAIR_RESET, tog_en: 1'b0,
    prio: PRIO_RESET, state: ARB_IDLE, gidx: '0, last_idx: '0, bm_cnt: '0,
    fair_cnt: '0, armed: 1'b0, tog_cnt: '0, tog_pulse: 1'b0, broken: '0,
    ignored: '0, served: '0, prdata: '0};

  function automatic logic [8:0] onehot(input logic [IDX_W-1:0] i);
    onehot = 9'(9'h001 << i);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction

  arb_regs_t st;
  arb_regs_t next_st;
  logic [8:0] reqv;
  logic [8:0] elig;
  logic [8:0] hi_elig;
  logic [8:0] cand;
  logic [8:0] owner;
  logic [8:0] others;
  logic own_req;
  logic bus_idle;
  logic frame_fall;
  logic found;
  logic [IDX_W-1:0] pick;
  logic [31:0] ctrl_val;
  logic [31:0] stat_val;
  logic setup;
  logic access;
  logic ctrl_hit;
  logic stat_hit;
  logic arb_on;
  logic drop;
  logic bm_expire;

  // Request vector: bit 0 internal, bits 1..8 external masters
  assign reqv = {~st.req_m2, int_req};
  assign elig = reqv & st.en & ~st.ignored;
  assign hi_elig = elig & st.prio;
  assign cand = (|hi_elig) ? hi_elig : elig;
  assign owner = onehot(st.gidx);
  assign others = elig & ~owner;
  assign own_req = |(owner & reqv & st.en);
  assign bus_idle = st.frame_m2 & st.irdy_m2;
  assign frame_fall = st.frame_prev & ~st.frame_m2;
  assign arb_on = st.strap_done & ~st.ext_arb;

  rr_pick #(
    .N(NUM_REQ),
    .IW(IDX_W)
  ) u_pick (
    .req(cand),
    .last(st.last_idx),
    .found(found),
    .idx(pick)
  );

  assign ctrl_val = {1'b0, st.prio, 1'b0, st.tog_en, st.fair, st.refresh_en, st.bmto_en,
                     st.ext_arb, st.en};

  always_comb
  begin
    stat_val = '0;
    stat_val[STAT_IDX_LSB +: IDX_W] = st.gidx;
    stat_val[STAT_GRANTED_BIT] = (st.state != ARB_IDLE);
    stat_val[STAT_BUSY_BIT] = (st.state == ARB_BUSY);
    stat_val[STAT_BROKEN_LSB +: 9] = st.broken;
    stat_val[STAT_IGNORED_LSB +: 9] = st.ignored;
  end

  // APB decode
  assign setup = psel & ~penable;
  assign access = psel & penable;

  always_comb
  begin
    ctrl_hit = 1'b0;
    stat_hit = 1'b0;
    if (paddr == AW'(ARB_CTRL_ADDR))
    begin
      ctrl_hit = 1'b1;
    end
    else if (paddr == AW'(ARB_STAT_ADDR))
    begin
      stat_hit = 1'b1;
    end
  end

  assign pready = access;
  assign pslverr = access & ~ctrl_hit & ~stat_hit;
  assign prdata = st.prdata;

  // Grant removal causes while granted
  assign bm_expire = st.bmto_en && st.state == ARB_GRANT && bus_idle && !frame_fall
                     && st.bm_cnt == BM_TIMEOUT_CYC - 5'h01;
  always_comb
  begin
    drop = 1'b0;
    if (!arb_on || !own_req)
    begin
      drop = 1'b1;
    end
    else if (bm_expire)
    begin
      drop = 1'b1;
    end
    else if (st.state == ARB_BUSY && st.armed && st.fair != 8'h00 && |others
             && st.fair_cnt == 8'h00)
    begin
      drop = 1'b1;
    end
  end

  always_comb
  begin
    logic [31:0] nw;
    logic [8:0] all_served;
    nw = merge(ctrl_val, pwdata, pstrb);
    all_served = '0;
    next_st = st;
    // Synchronisers
    next_st.req_m1 = req_l;
    next_st.req_m2 = st.req_m1;
    next_st.frame_m1 = frame_l;
    next_st.frame_m2 = st.frame_m1;
    next_st.frame_prev = st.frame_m2;
    next_st.irdy_m1 = irdy_l;
    next_st.irdy_m2 = st.irdy_m1;
    next_st.strap_m1 = arbiter_select_strap;
    next_st.strap_m2 = st.strap_m1;
    // Strap capture after reset release
    if (!st.strap_done)
    begin
      next_st.ext_arb = st.strap_m2;
      next_st.strap_cnt = st.strap_cnt + 2'h1;
      if (st.strap_cnt == STRAP_SETTLE_CYC)
      begin
        next_st.strap_done = 1'b1;
      end
    end
    // APB access
    if (setup)
    begin
      next_st.prdata = ctrl_hit ? ctrl_val : (stat_hit ? stat_val : 32'h0000_0000);
    end
    if (access && pwrite && ctrl_hit)
    begin
      next_st.en = nw[EN_LSB +: 9];
      next_st.bmto_en = nw[BMTO_EN_BIT];
      next_st.refresh_en = nw[REFRESH_EN_BIT];
      next_st.fair = nw[FAIR_LSB +: 8];
      next_st.tog_en = nw[TOG_EN_BIT];
      next_st.prio = nw[PRIO_LSB +: 9];
    end
    // Toggle pulse timing
    next_st.tog_pulse = 1'b0;
    if (st.tog_cnt != 2'h0)
    begin
      next_st.tog_cnt = st.tog_cnt + 2'h1;
      if (st.tog_cnt == TOG_DELAY_CYC - 2'h1)
      begin
        next_st.tog_pulse = st.tog_en;
        next_st.tog_cnt = 2'h0;
      end
    end
    // Broken master refresh
    if (st.refresh_en)
    begin
      for (int i = 1; i < NUM_REQ; i++)
      begin
        all_served = st.served | ~(reqv & st.en) | onehot(IDX_W'(i));
        if (st.broken[i] && &all_served)
        begin
          next_st.broken[i] = 1'b0;
          next_st.ignored[i] = 1'b0;
          next_st.served = '0;
        end
      end
    end
    // Broken master is ignored once it releases its request
    // A master refreshed in this cycle must not be marked ignored again
    next_st.ignored = next_st.ignored | (next_st.broken & ~reqv);
    // Arbitration
    case (st.state)
      ARB_IDLE:
      begin
        if (arb_on && found)
        begin
          next_st.state = ARB_GRANT;
          next_st.gidx = pick;
          next_st.last_idx = pick;
          next_st.bm_cnt = '0;
          next_st.fair_cnt = st.fair;
          next_st.armed = 1'b0;
          next_st.tog_cnt = '0;
          next_st.served = next_st.served | onehot(pick);
        end
      end
      ARB_GRANT:
      begin
        if (drop)
        begin
          next_st.state = ARB_IDLE;
          if (bm_expire && st.gidx != '0)
          begin
            next_st.broken = next_st.broken | owner;
            next_st.served = '0;
          end
        end
        else if (frame_fall)
        begin
          next_st.state = ARB_BUSY;
          next_st.armed = 1'b1;
          next_st.tog_cnt = 2'h1;
        end
        else if (bus_idle && st.bmto_en)
        begin
          next_st.bm_cnt = st.bm_cnt + 5'h01;
        end
      end
      ARB_BUSY:
      begin
        if (drop)
        begin
          next_st.state = ARB_IDLE;
        end
        else if (st.armed && |others && st.fair_cnt != 8'h00)
        begin
          next_st.fair_cnt = st.fair_cnt - 8'h01;
        end
      end
      default:
      begin
        next_st.state = ARB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= RESET_ST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Grant outputs: gnt_l active low, int_gnt active high
  logic [8:0] gnt_vec;
  assign gnt_vec = (st.state != ARB_IDLE && !st.tog_pulse) ? owner : 9'h000;
  assign int_gnt = gnt_vec[0];
  assign gnt_l = ~gnt_vec[8:1];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_new_grant;
    st.state == ARB_IDLE ##1 st.state == ARB_GRANT;
  endsequence

  sequence s_frame_start;
    st.state == ARB_GRANT && frame_fall && !drop && st.tog_en;
  endsequence

  sequence s_one_clock_gap;
    !st.tog_pulse ##1 st.tog_pulse ##1 !st.tog_pulse;
  endsequence

  chk_grant_enabled: assert property (s_new_grant |-> st.en[st.gidx])
    else $error("grant given to a disabled requester");

  chk_strap_capture: assert property ($rose(st.strap_done) |-> st.ext_arb == $past(st.strap_m2))
    else $error("selection bit does not match strap");

  chk_ext_no_grant: assert property (st.strap_done && st.ext_arb |=> gnt_vec == 9'h000)
    else $error("grant driven while external arbiter selected");

  chk_broken_expire: assert property (bm_expire |=> st.state == ARB_IDLE && gnt_vec == 9'h000)
    else $error("grant kept after broken master timeout");

  chk_timeout_off: assert property (st.state == ARB_GRANT && !st.bmto_en && own_req && arb_on
                                    |=> st.state != ARB_IDLE)
    else $error("grant removed with timeout disabled");

  chk_bm_count: assert property (st.state == ARB_GRANT && st.bmto_en && bus_idle && !frame_fall
                                 && !drop |=> st.bm_cnt == $past(st.bm_cnt) + 5'h01)
    else $error("broken timeout count not advancing");

  chk_ignore_forever: assert property (!st.refresh_en |=> (st.ignored & $past(st.ignored))
                                       == $past(st.ignored))
    else $error("ignored master restored without refresh");

  chk_fair_reload: assert property (s_new_grant |-> st.fair_cnt == $past(st.fair))
    else $error("fairness counter not reloaded");

  chk_fair_armed: assert property (st.state == ARB_GRANT ##1 st.state == ARB_GRANT
                                   |-> $stable(st.fair_cnt))
    else $error("fairness counter moved before frame start");

  chk_fair_zero: assert property (st.state == ARB_BUSY && st.fair == 8'h00 && own_req && arb_on
                                  |=> st.state == ARB_BUSY)
    else $error("grant removed for fairness with zero setting");

  chk_toggle_gap: assert property (s_frame_start |-> ##1 s_one_clock_gap)
    else $error("grant toggle not one clock two clocks after frame");

  chk_no_toggle: assert property (!st.tog_en && !$past(st.tog_en) |-> !st.tog_pulse)
    else $error("grant toggled while toggling disabled");

endmodule // pci_secondary_arbiter_control

// ==== test/pci_master_model.sv ====
// Behavioural PCI bus masters that run a frame whenever granted and not lazy
`timescale 1ns/100ps
module pci_master_model #(
  parameter int FLEN = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control from the bench
  input wire logic [7:0] want,
  input wire logic [7:0] lazy,
  // PCI bus
  input wire logic [7:0] gnt_l,
  output logic [7:0] req_l,
  output logic frame_l,
  output logic irdy_l
);
  int cnt;
  // Bus lines sit on pull-ups, so an idle bus reads high
  assign req_l = ~want;
  assign frame_l = (cnt < 2);
  assign irdy_l = (cnt == 0);
  // A lazy master never starts its frame, to provoke the broken timeout
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt <= 0;
    else if (cnt != 0)
      cnt <= cnt - 1;
    else if (|(~gnt_l & want & ~lazy))
      cnt <= FLEN;
endmodule // pci_master_model

// ==== test/test_pci_secondary_arbiter_control.sv ====
// Self-checking bench for the secondary bus arbiter
`timescale 1ns/100ps
module test_pci_secondary_arbiter_control;
  import pci_arb_pkg::*;
  localparam logic [31:0] CTRL_RST = 32'h004081ff;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, int_req, int_gnt;
  logic frame_l, irdy_l, strap, er;
  logic [7:0] paddr, req_l, gnt_l, want, lazy;
  logic [31:0] pwdata, prdata, rd;
  int failures = 0;
  int checked = 0;
  int n, g;

  pci_secondary_arbiter_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .int_req(int_req),
    .int_gnt(int_gnt), .req_l(req_l), .gnt_l(gnt_l), .frame_l(frame_l),
    .irdy_l(irdy_l), .arbiter_select_strap(strap));
  pci_master_model masters (.pclk(pclk), .presetn(presetn), .want(want), .lazy(lazy),
    .gnt_l(gnt_l), .req_l(req_l), .frame_l(frame_l), .irdy_l(irdy_l));

  initial
  begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end

  task finish_test;
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; response taken at the edge where pready is high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task wr(input logic [31:0] d);
    apb(1, ARB_CTRL_ADDR, d);
  endtask

  // Requester 0 is internal, 1 to 8 are the external masters
  function automatic logic granted(input int i);
    return (i == 0) ? int_gnt : !gnt_l[i-1];
  endfunction

  task wait_for(input int i, input logic lvl, input int lim);
    n = 0;
    while (granted(i) !== lvl && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  task count_on(input int i, input int lim);
    g = 0;
    repeat (lim)
    begin
      @(posedge pclk);
      if (granted(i) === 1'b1)
        g++;
    end
  endtask

  initial
  begin
    #200000;
    failures++;
    finish_test;
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, int_req, want, lazy, strap} = '0;
    presetn = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    apb(0, ARB_CTRL_ADDR, 0);
    chk("ctrl reset", rd, CTRL_RST);
    wr(CTRL_RST | 32'h200);
    apb(0, ARB_CTRL_ADDR, 0);
    chk("ctrl bit9", rd, CTRL_RST);
    apb(0, 8'h44, 0);
    chk("unmapped err", 32'(er), 1);
    chk("unmapped data", rd, 0);
    int_req <= 1;
    wait_for(0, 1, 20);
    chk("internal grant", 32'(n < 20), 1);
    int_req <= 0;
    wait_for(0, 0, 20);
    wr(32'h004081fa);
    int_req <= 1;
    want <= 8'h02;
    count_on(0, 40);
    chk("internal off", g, 0);
    count_on(2, 40);
    chk("master2 off", g, 0);
    int_req <= 0;
    want <= 0;
    for (int t = 0; t < 2; t++)
    begin
      wr(t ? 32'h005081ff : CTRL_RST);
      want <= 8'h01;
      wait_for(1, 1, 20);
      n = 0;
      while (frame_l !== 1'b0 && n < 20)
      begin
        @(posedge pclk);
        n++;
      end
      count_on(1, 9);
      chk("gnt toggle", 32'(9 - g), 32'(t));
      want <= 0;
      repeat (30) @(posedge pclk);
    end
    wr(32'h004085ff);
    lazy <= 8'h01;
    want <= 8'h01;
    wait_for(1, 1, 20);
    wait_for(1, 0, 40);
    chk("broken timeout", 32'(n >= 16 && n <= 20), 1);
    want <= 0;
    lazy <= 0;
    repeat (3) @(posedge pclk);
    want <= 8'h01;
    count_on(1, 40);
    chk("broken ignored", g, 0);
    wr(CTRL_RST);
    lazy <= 8'h04;
    want <= 8'h04;
    wait_for(3, 1, 20);
    count_on(3, 40);
    chk("no timeout", g, 40);
    want <= 0;
    lazy <= 0;
    repeat (5) @(posedge pclk);
    wr(CTRL_RST | 32'h800);
    want <= 8'h01;
    wait_for(1, 1, 20);
    chk("broken refresh", 32'(n < 20), 1);
    want <= 0;
    repeat (30) @(posedge pclk);
    for (int t = 0; t < 2; t++)
    begin
      wr(t ? CTRL_RST : 32'h004001ff);
      want <= 8'h08;
      wait_for(4, 1, 20);
      want <= 8'h18;
      count_on(5, 60);
      chk("fairness", 32'(g != 0), 32'(t));
      want <= 0;
      repeat (30) @(posedge pclk);
    end
    strap <= 1;
    presetn <= 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    apb(0, ARB_CTRL_ADDR, 0);
    chk("strap reset", rd, CTRL_RST | 32'h200);
    finish_test;
  end
endmodule // test_pci_secondary_arbiter_control
